/* dfm_ctrl.sv */
// module: fire-mode, retry target and avoidance control for a motor drive
`timescale 1ns/1ns

// How it works
// - primary mask bits 0,1,2,4,5 enable retry
// - secondary mask bits 0,1 enable retry
// - eight-bit masks, retry only when bit set
// - phase loss lowers frequency or stops alarmed
// - voltage shortage keeps lowering frequency
// - fire mode ignores alarms, keeps running
// - mode 0 follows filtered input level
// - mode 1 toggles per complete pulse
// - mode 2 latches on at assertion
// - ignore input changes shorter than confirmation
// - fixed fire frequency 0.1 to 120.0 Hz
// - zero frequency setting inherits normal command
// - direction 0 follows run command only
// - direction 2 forward, 3 reverse forced
// - start method 0 normal, 1 speed search
// - trip in fire mode auto-clears after delay
module dfm_ctrl
  import dfm_pkg::*;
#(
  parameter int unsigned TICK_CYC = TENTH_S_CYC // cycles per 0.1 s; shortened only for simulation
)
(
  input wire logic clk, // 50 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic irq, // level interrupt
  input wire logic emergency_request_in, // emergency terminal
  input wire dfm_trip_s trip_in, // detected trip pulses
  input wire logic phase_loss_in, // supply phase loss level
  input wire logic volt_short_in, // output below command
  input wire logic run_cmd_in, // normal run command
  input wire logic run_fwd_in, // normal direction, 1 fwd
  output dfm_cmd_s cmd // drive commands
);

  typedef struct packed {
    logic [7:0] retry1;
    logic [7:0] retry2;
    logic [6:0] ctrl;
    logic [6:0] confirm;
    logic [10:0] freq;
    logic [7:0] clrdly;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
    logic in_filt;
    logic [7:0] tenth_cnt_hi;
    logic [23:0] tick_cnt;
    logic [7:0] filt_cnt;
    logic fire;
    logic tripped;
    logic [7:0] clr_cnt;
    dfm_cmd_s cmd;
  } dfm_state_s;

  dfm_state_s s_q;
  dfm_state_s s_d;

  function automatic logic [7:0] clamp_tenths(input logic [31:0] v, input int unsigned lo, input int unsigned hi);
    if (v < lo) begin
      return 8'(lo);
    end else if (v > hi) begin
      return 8'(hi);
    end
    return v[7:0];
  endfunction : clamp_tenths

  logic tick;
  logic in_raw_diff;
  logic confirmed;
  logic rise;
  logic fall;
  logic any_trip;
  logic retry_ok;
  dfm_mode_e mode;
  dfm_dir_e dir;

  assign mode = dfm_mode_e'(s_q.ctrl[CTRL_MODE_LSB +: 2]);
  assign dir = dfm_dir_e'(s_q.ctrl[CTRL_DIR_LSB +: 2]);
  assign tick = (s_q.tick_cnt == 24'(TICK_CYC - 1));
  assign in_raw_diff = (emergency_request_in != s_q.in_filt);
  assign confirmed = in_raw_diff && tick && (s_q.filt_cnt + 8'h01 >= 8'(s_q.confirm));
  assign rise = confirmed && !s_q.in_filt;
  assign fall = confirmed && s_q.in_filt;
  assign any_trip = |trip_in;
  assign retry_ok = (trip_in.oc & s_q.retry1[R1_OC]) | (trip_in.ov & s_q.retry1[R1_OV]) |
                    (trip_in.oh & s_q.retry1[R1_OH]) | (trip_in.ol & s_q.retry1[R1_OL]) |
                    (trip_in.moh & s_q.retry1[R1_MOH]) |
                    (trip_in.ext & s_q.retry2[R2_EXT]) | (trip_in.uv & s_q.retry2[R2_UV]);

  always_comb begin
    logic fire_n;
    logic [31:0] rv;
    logic [3:0] ev;
    s_d = s_q;
    fire_n = s_q.fire;
    rv = 32'h0000_0000;
    ev = 4'h0;

    // =====================================================
    // register writes
    if (wr) begin
      unique case (addr)
        ADDR_RETRY1: s_d.retry1 = wdata[7:0];
        ADDR_RETRY2: s_d.retry2 = wdata[7:0];
        ADDR_CTRL: s_d.ctrl = wdata[6:0];
        ADDR_CONFIRM: s_d.confirm = 7'(clamp_tenths(wdata, CONFIRM_MIN, CONFIRM_MAX));
        ADDR_FREQ: begin
          // zero keeps inherit; nonzero clamps into range
          if (wdata == 32'(FREQ_INHERIT)) begin
            s_d.freq = FREQ_INHERIT;
          end else if (wdata > 32'(FREQ_MAX)) begin
            s_d.freq = 11'(FREQ_MAX);
          end else begin
            s_d.freq = wdata[10:0];
          end
        end
        ADDR_CLRDLY: s_d.clrdly = clamp_tenths(wdata, CLEAR_MIN, CLEAR_MAX);
        ADDR_IRQ_MASK: s_d.irq_mask = wdata[3:0];
        default: ;
      endcase
    end

    // =====================================================
    // read path, one cycle latency
    if (rd) begin
      unique case (addr)
        ADDR_RETRY1: rv[7:0] = s_q.retry1;
        ADDR_RETRY2: rv[7:0] = s_q.retry2;
        ADDR_CTRL: rv[6:0] = s_q.ctrl;
        ADDR_CONFIRM: rv[6:0] = s_q.confirm;
        ADDR_FREQ: rv[10:0] = s_q.freq;
        ADDR_CLRDLY: rv[7:0] = s_q.clrdly;
        ADDR_STATUS: rv[3:0] = {s_q.tripped, s_q.in_filt, s_q.cmd.run, s_q.fire};
        ADDR_IRQ_STAT: rv[3:0] = s_q.irq_stat;
        ADDR_IRQ_MASK: rv[3:0] = s_q.irq_mask;
        default: rv = 32'h0000_0000;
      endcase
    end
    s_d.rdata = rv;

    // =====================================================
    // input confirmation filter, counted in 0.1 s ticks
    s_d.tick_cnt = tick ? 24'h00_0000 : s_q.tick_cnt + 24'h00_0001;
    if (!in_raw_diff) begin
      s_d.filt_cnt = 8'h00;
    end else if (confirmed) begin
      s_d.filt_cnt = 8'h00;
      s_d.in_filt = emergency_request_in;
    end else if (tick) begin
      s_d.filt_cnt = s_q.filt_cnt + 8'h01;
    end

    // =====================================================
    // fire mode state
    unique case (mode)
      MODE_LEVEL: begin
        if (rise) fire_n = 1'b1;
        if (fall) fire_n = 1'b0;
      end
      MODE_TOGGLE: begin
        if (fall) fire_n = !s_q.fire;
      end
      MODE_LATCH: begin
        if (rise) fire_n = 1'b1;
      end
      default: ;
    endcase
    s_d.fire = fire_n;
    if (fire_n && !s_q.fire) ev[IRQ_ENTER] = 1'b1;
    if (!fire_n && s_q.fire) ev[IRQ_EXIT] = 1'b1;

    // =====================================================
    // trip handling and auto clear during fire mode
    s_d.cmd.retry = any_trip && retry_ok;
    s_d.cmd.trip_clear = 1'b0;
    if (any_trip && s_q.fire) begin
      s_d.tripped = 1'b1;
      s_d.clr_cnt = 8'h00;
    end else if (s_q.tripped) begin
      if (!s_q.fire) begin
        s_d.tripped = 1'b0;
      end else if (tick) begin
        if (s_q.clr_cnt + 8'h01 >= s_q.clrdly) begin
          s_d.tripped = 1'b0;
          s_d.cmd.trip_clear = 1'b1;
          s_d.clr_cnt = 8'h00;
          ev[IRQ_AUTOCLR] = 1'b1;
        end else begin
          s_d.clr_cnt = s_q.clr_cnt + 8'h01;
        end
      end
    end
    // alarms do not stop the drive while fire mode runs
    s_d.cmd.trip_stop = any_trip && !s_q.fire && !retry_ok;

    // =====================================================
    // direction, frequency and start selection
    s_d.cmd.fire_active = fire_n;
    if (fire_n) begin
      unique case (dir)
        DIR_FWD: begin
          s_d.cmd.run = 1'b1;
          s_d.cmd.fwd = 1'b1;
          s_d.cmd.rev = 1'b0;
        end
        DIR_REV: begin
          s_d.cmd.run = 1'b1;
          s_d.cmd.fwd = 1'b0;
          s_d.cmd.rev = 1'b1;
        end
        default: begin
          s_d.cmd.run = run_cmd_in;
          s_d.cmd.fwd = run_cmd_in && run_fwd_in;
          s_d.cmd.rev = run_cmd_in && !run_fwd_in;
        end
      endcase
      s_d.cmd.use_emerg_freq = (s_q.freq != FREQ_INHERIT);
      s_d.cmd.freq = s_q.freq;
    end else begin
      s_d.cmd.run = run_cmd_in;
      s_d.cmd.fwd = run_cmd_in && run_fwd_in;
      s_d.cmd.rev = run_cmd_in && !run_fwd_in;
      s_d.cmd.use_emerg_freq = 1'b0;
      s_d.cmd.freq = FREQ_INHERIT;
    end
    // start method pulse on entry
    s_d.cmd.speed_search = ev[IRQ_ENTER] && s_q.ctrl[CTRL_START_BIT];
    s_d.cmd.normal_start = ev[IRQ_ENTER] && !s_q.ctrl[CTRL_START_BIT];

    // =====================================================
    // avoidance operations
    s_d.cmd.freq_reduce = (phase_loss_in && s_q.ctrl[CTRL_PHASE_BIT]) ||
                          (volt_short_in && s_q.ctrl[CTRL_VOLT_BIT]);
    s_d.cmd.phase_alarm_stop = phase_loss_in && !s_q.ctrl[CTRL_PHASE_BIT] && !fire_n;
    // event on the start of the stop only, so a held loss outside fire mode does not re-arm it
    if (s_d.cmd.phase_alarm_stop && !s_q.cmd.phase_alarm_stop) ev[IRQ_PHASE] = 1'b1;

    // =====================================================
    // interrupts: set wins over write-one-to-clear
    if (wr && addr == ADDR_IRQ_STAT) begin
      s_d.irq_stat = s_q.irq_stat & ~wdata[3:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.retry1 <= RST_BYTE;
      s_q.retry2 <= RST_BYTE;
      s_q.ctrl <= RST_CTRL;
      s_q.confirm <= RST_CONFIRM;
      s_q.freq <= RST_FREQ;
      s_q.clrdly <= RST_CLRDLY;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign cmd = s_q.cmd;

endmodule : dfm_ctrl

/* dfm_ctrl_assertions.sv */
// checker: port-level properties of the fire-mode and retry control block
`timescale 1ns/1ns
module dfm_ctrl_chk
  import dfm_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_b, // reset
  input wire logic [7:0] addr, // address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire dfm_trip_s trip_in, // trips
  input wire logic phase_loss_in, // phase loss
  input wire logic volt_short_in, // volt short
  input wire dfm_cmd_s cmd // commands
);
  // =====================================
  // shadow registers, the checker sees only the bus
  logic [7:0] m1_q, m2_q, ct_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m1_q <= 8'h00;
      m2_q <= 8'h00;
      ct_q <= 8'h00;
    end else if (wr) begin
      if (addr == ADDR_RETRY1) m1_q <= wdata[7:0];
      if (addr == ADDR_RETRY2) m2_q <= wdata[7:0];
      if (addr == ADDR_CTRL) ct_q <= wdata[7:0];
    end
  end
  wire hit = (trip_in.oc & m1_q[0]) | (trip_in.ov & m1_q[1]) | (trip_in.oh & m1_q[2]) | (trip_in.ol & m1_q[4])
    | (trip_in.moh & m1_q[5]) | (trip_in.ext & m2_q[0]) | (trip_in.uv & m2_q[1]);
  // =====================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0) else $error("read data outside slot");
  AST_RD_MASK: assert property (rd && addr == ADDR_RETRY1 |=> rdata == {24'h0, m1_q}) else $error("mask read");
  AST_RD_HOLE: assert property (rd && addr > 8'h20 |=> rdata == 32'h0) else $error("unmapped read");
  AST_RETRY: assert property (hit |=> cmd.retry && !cmd.trip_stop) else $error("retry missing");
  AST_NO_RETRY: assert property ((|trip_in) && !hit && !cmd.fire_active |=> cmd.trip_stop && !cmd.retry)
    else $error("trip stop missing");
  AST_PH_AVOID: assert property (phase_loss_in && ct_q[0] |=> cmd.freq_reduce && !cmd.phase_alarm_stop)
    else $error("phase avoid");
  AST_PH_STOP: assert property (phase_loss_in && !ct_q[0] && !cmd.fire_active |=> cmd.phase_alarm_stop)
    else $error("phase stop");
  AST_VOLT: assert property (volt_short_in && ct_q[1] |=> cmd.freq_reduce) else $error("volt avoid");
  AST_FREQ_OFF: assert property (!cmd.fire_active |-> cmd.freq == 11'h000) else $error("freq outside fire");
  AST_FIRE_NO_STOP: assert property ((|trip_in) && cmd.fire_active |=> !cmd.trip_stop)
    else $error("trip stop in fire");
  AST_ENTRY_START: assert property ($rose(cmd.fire_active) |-> cmd.speed_search == $past(ct_q[6])
    && cmd.normal_start == !$past(ct_q[6])) else $error("start pulse on entry");
  cover property (hit ##1 cmd.retry);
  cover property (phase_loss_in && !ct_q[0] ##1 cmd.phase_alarm_stop);
  cover property (rd && addr > 8'h20);
  cover property ($rose(cmd.fire_active) && cmd.speed_search);
  cover property (cmd.fire_active && cmd.trip_clear);
endmodule : dfm_ctrl_chk

bind dfm_ctrl dfm_ctrl_chk u_chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .trip_in(trip_in), .phase_loss_in(phase_loss_in), .volt_short_in(volt_short_in), .cmd(cmd));

/* dfm_far_side.sv */
// partner: emergency terminal, supply and motor fault sources
`timescale 1ns/1ns
module dfm_far_side
  import dfm_pkg::*;
(
  input wire logic clk, // clock
  output logic emergency_request_in, // terminal
  output dfm_trip_s trip_in, // fault pulses
  output logic phase_loss_in, // supply loss
  output logic volt_short_in // voltage short
);
  initial begin
    emergency_request_in = 1'b0;
    trip_in = '0;
    phase_loss_in = 1'b0;
    volt_short_in = 1'b0;
  end
  // one-cycle pulse, index 6 is oc down to 0 for uv
  task automatic fault(input int idx);
    @(posedge clk);
    trip_in <= dfm_trip_s'(7'h01 << idx);
    @(posedge clk);
    trip_in <= '0;
  endtask : fault
  // a hold shorter than confirmation breaks the terminal rule on purpose
  task automatic hold_terminal(input int n);
    @(posedge clk);
    emergency_request_in <= 1'b1;
    repeat (n) @(posedge clk);
    emergency_request_in <= 1'b0;
  endtask : hold_terminal
  // terminal level, kept by the caller for longer than confirmation
  task automatic terminal(input logic lvl);
    @(posedge clk);
    emergency_request_in <= lvl;
  endtask : terminal
  task automatic supply(input logic ph, input logic vs);
    @(posedge clk);
    phase_loss_in <= ph;
    volt_short_in <= vs;
  endtask : supply
endmodule : dfm_far_side

/* dfm_pkg.sv */
// package: constants and types for the drive fire-mode and retry control block
package dfm_pkg;

  // =====================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TENTH_S_MS = 100;
  localparam int unsigned TENTH_S_CYC = CLK_HZ / 1000 * TENTH_S_MS;
  localparam int unsigned CONFIRM_MIN = 5;    // 0.5 s in tenths
  localparam int unsigned CONFIRM_MAX = 100;  // 10.0 s in tenths
  localparam int unsigned CLEAR_MIN = 5;      // 0.5 s in tenths
  localparam int unsigned CLEAR_MAX = 200;    // 20.0 s in tenths
  localparam int unsigned FREQ_MIN = 1;       // 0.1 Hz in tenths
  localparam int unsigned FREQ_MAX = 1200;    // 120.0 Hz in tenths
  localparam logic [10:0] FREQ_INHERIT = 11'h000;

  // =====================================================
  // register map, word offsets given as byte addresses
  localparam logic [7:0] ADDR_RETRY1 = 8'h00;
  localparam logic [7:0] ADDR_RETRY2 = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CONFIRM = 8'h0C;
  localparam logic [7:0] ADDR_FREQ = 8'h10;
  localparam logic [7:0] ADDR_CLRDLY = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

  // ctrl register fields
  localparam int unsigned CTRL_PHASE_BIT = 0;
  localparam int unsigned CTRL_VOLT_BIT = 1;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_DIR_LSB = 4;
  localparam int unsigned CTRL_START_BIT = 6;

  // retry mask bits
  localparam int unsigned R1_OC = 0;
  localparam int unsigned R1_OV = 1;
  localparam int unsigned R1_OH = 2;
  localparam int unsigned R1_OL = 4;
  localparam int unsigned R1_MOH = 5;
  localparam int unsigned R2_EXT = 0;
  localparam int unsigned R2_UV = 1;

  // interrupt bits
  localparam int unsigned IRQ_ENTER = 0;
  localparam int unsigned IRQ_EXIT = 1;
  localparam int unsigned IRQ_AUTOCLR = 2;
  localparam int unsigned IRQ_PHASE = 3;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_CTRL = 7'h00;
  localparam logic [6:0] RST_CONFIRM = 7'h05;
  localparam logic [10:0] RST_FREQ = 11'h000;
  localparam logic [7:0] RST_CLRDLY = 8'h05;

  typedef enum logic [1:0] {
    MODE_LEVEL = 2'b00,
    MODE_TOGGLE = 2'b01,
    MODE_LATCH = 2'b10
  } dfm_mode_e;

  typedef enum logic [1:0] {
    DIR_FOLLOW = 2'b00,
    DIR_FWD = 2'b10,
    DIR_REV = 2'b11
  } dfm_dir_e;

  // trip inputs grouped
  typedef struct packed {
    logic oc;
    logic ov;
    logic oh;
    logic ol;
    logic moh;
    logic ext;
    logic uv;
  } dfm_trip_s;

  // drive commands out
  typedef struct packed {
    logic run;
    logic fwd;
    logic rev;
    logic use_emerg_freq;
    logic [10:0] freq;
    logic speed_search;
    logic normal_start;
    logic freq_reduce;
    logic phase_alarm_stop;
    logic trip_stop;
    logic retry;
    logic trip_clear;
    logic fire_active;
  } dfm_cmd_s;

endpackage : dfm_pkg

/* tb_top.sv */
// testbench: registers, retry targets, avoidance and interrupt
`timescale 1ns/1ns
module tb_top
  import dfm_pkg::*;
;
  logic clk, rst_b, wr, rd, irq, run_cmd, run_fwd, emerg, ph, vs;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  dfm_trip_s trip;
  dfm_cmd_s cmd;
  int miscompares = 0;
  int total_checks = 0;
  logic [31:0] rst_tab [10] = '{32'h0, 32'h0, 32'h0, 32'h5, 32'h0, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0] wa [7] = '{ADDR_CONFIRM, ADDR_CONFIRM, ADDR_FREQ, ADDR_CLRDLY, ADDR_CLRDLY, ADDR_STATUS, 8'h24};
  logic [31:0] wd [7] = '{32'h0, 32'hC8, 32'h7D0, 32'hFF, 32'h0, 32'hF, 32'hFF};
  logic [31:0] we [7] = '{32'h5, 32'h64, 32'h4B0, 32'hC8, 32'h5, 32'h0, 32'h0};
  localparam int unsigned TB_TICK = 10; // short tick keeps fire-mode waits inside the run
  dfm_ctrl #(.TICK_CYC(TB_TICK)) u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .emergency_request_in(emerg), .trip_in(trip), .phase_loss_in(ph), .volt_short_in(vs),
    .run_cmd_in(run_cmd), .run_fwd_in(run_fwd), .cmd(cmd));
  dfm_far_side u_far (.clk(clk), .emergency_request_in(emerg), .trip_in(trip), .phase_loss_in(ph),
    .volt_short_in(vs));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(what, exp, rdata);
  endtask : bus_rd
  // every trip group once; the two outcome bits are retry then stop
  task automatic trips(input logic [7:0] m1, input logic [7:0] m2, input logic [1:0] exp);
    bus_wr(ADDR_RETRY1, {24'h0, m1});
    bus_wr(ADDR_RETRY2, {24'h0, m2});
    for (int i = 0; i < 7; i++) begin
      u_far.fault(i);
      #1 check("trip outcome", {30'h0, exp}, {30'h0, cmd.retry, cmd.trip_stop});
    end
  endtask : trips
  task automatic supply_chk(input logic p, input logic v, input logic [1:0] exp);
    u_far.supply(p, v);
    repeat (2) @(posedge clk);
    #1 check("reduce alarm", {30'h0, exp}, {30'h0, cmd.freq_reduce, cmd.phase_alarm_stop});
  endtask : supply_chk
  // bounded wait on fire state (k=0) or the trip clear pulse (k=1); a timeout fails the compare
  task automatic wait_on(input string what, input int k, input logic exp);
    int n;
    logic v;
    n = 0;
    v = k ? cmd.trip_clear : cmd.fire_active;
    while (v !== exp && n < 80) begin
      @(posedge clk);
      #1 n++;
      v = k ? cmd.trip_clear : cmd.fire_active;
    end
    check(what, {31'h0, exp}, {31'h0, v});
  endtask : wait_on
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    rst_b = 1'b0;
    {addr, wdata, wr, rd, run_cmd} = '0;
    run_fwd = 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, the last slot is unmapped
    for (int i = 0; i < 10; i++) bus_rd("reset value", 8'(4 * i), rst_tab[i]);
    bus_wr(ADDR_RETRY1, 32'hA5);
    bus_rd("mask one", ADDR_RETRY1, 32'hA5);
    bus_wr(ADDR_RETRY2, 32'hFF);
    bus_rd("mask two", ADDR_RETRY2, 32'hFF);
    // clamped settings, read-only status, ignored hole
    for (int i = 0; i < 7; i++) begin
      bus_wr(wa[i], wd[i]);
      bus_rd("setting", wa[i], we[i]);
    end
    trips(8'h37, 8'h03, 2'b10);
    trips(8'hC8, 8'hFC, 2'b01);
    bus_wr(ADDR_CTRL, 32'h0);
    supply_chk(1'b1, 1'b0, 2'b01);
    check("irq masked", 32'h0, {31'h0, irq});
    bus_rd("irq status", ADDR_IRQ_STAT, 32'h8);
    bus_wr(ADDR_IRQ_MASK, 32'h8);
    repeat (2) @(posedge clk);
    #1 check("irq raised", 32'h1, {31'h0, irq});
    u_far.supply(1'b0, 1'b0);
    bus_wr(ADDR_IRQ_STAT, 32'h8);
    repeat (2) @(posedge clk);
    #1 check("irq cleared", 32'h0, {31'h0, irq});
    bus_wr(ADDR_CTRL, 32'h1);
    supply_chk(1'b1, 1'b0, 2'b10);
    bus_wr(ADDR_CTRL, 32'h2);
    supply_chk(1'b0, 1'b1, 2'b10);
    bus_wr(ADDR_CTRL, 32'h0);
    supply_chk(1'b0, 1'b1, 2'b00);
    // fire mode: 0.5 s confirmation, 60.0 Hz, forced forward, speed search on entry
    bus_wr(ADDR_CONFIRM, 32'h5);
    bus_wr(ADDR_FREQ, 32'h258);
    bus_wr(ADDR_IRQ_STAT, 32'hF);
    bus_wr(ADDR_IRQ_MASK, 32'h1);
    bus_wr(ADDR_CTRL, 32'h60);
    // a terminal hold far below confirmation must not start fire mode
    u_far.hold_terminal(20);
    repeat (60) @(posedge clk);
    #1 check("fire after short hold", 32'h0, {31'h0, cmd.fire_active});
    u_far.terminal(1'b1);
    wait_on("fire on level", 0, 1'b1);
    check("entry start", 32'h2, {30'h0, cmd.speed_search, cmd.normal_start});
    check("forced forward", 32'h6, {29'h0, cmd.run, cmd.fwd, cmd.rev});
    check("fire freq", 32'hA58, {20'h0, cmd.use_emerg_freq, cmd.freq});
    check("irq on entry", 32'h1, {31'h0, irq});
    u_far.fault(6);
    #1 check("trip in fire", 32'h0, {30'h0, cmd.retry, cmd.trip_stop});
    wait_on("auto trip clear", 1, 1'b1);
    bus_rd("status in fire", ADDR_STATUS, 32'h7);
    bus_wr(ADDR_CTRL, 32'h0);
    bus_wr(ADDR_FREQ, 32'h0);
    repeat (2) @(posedge clk);
    #1 check("follow without run", 32'h1, {30'h0, cmd.run, cmd.fire_active});
    check("inherit freq", 32'h0, {20'h0, cmd.use_emerg_freq, cmd.freq});
    @(posedge clk);
    run_cmd <= 1'b1;
    run_fwd <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("follow run reverse", 32'h5, {29'h0, cmd.run, cmd.fwd, cmd.rev});
    u_far.terminal(1'b0);
    wait_on("fire off level", 0, 1'b0);
    bus_rd("irq events", ADDR_IRQ_STAT, 32'h7);
    // toggle: only a complete pulse changes the state
    bus_wr(ADDR_CTRL, 32'h4);
    u_far.terminal(1'b1);
    repeat (60) @(posedge clk);
    #1 check("toggle waits for pulse end", 32'h0, {31'h0, cmd.fire_active});
    u_far.terminal(1'b0);
    wait_on("toggle on", 0, 1'b1);
    check("entry start normal", 32'h1, {30'h0, cmd.speed_search, cmd.normal_start});
    u_far.terminal(1'b1);
    repeat (60) @(posedge clk);
    #1 check("toggle holds", 32'h1, {31'h0, cmd.fire_active});
    u_far.terminal(1'b0);
    wait_on("toggle off", 0, 1'b0);
    // latch, then a reset in mid-run must clear it
    bus_wr(ADDR_CTRL, 32'h8);
    u_far.terminal(1'b1);
    wait_on("latch on", 0, 1'b1);
    u_far.terminal(1'b0);
    repeat (70) @(posedge clk);
    #1 check("latch holds", 32'h1, {31'h0, cmd.fire_active});
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1 check("fire after reset", 32'h0, {31'h0, cmd.fire_active});
    bus_rd("mask after reset", ADDR_RETRY1, 32'h0);
    wrap_up();
  end
endmodule : tb_top
